// ### design/kwu_top.sv
// Key wakeup interrupt block with APB registers, detection and wakeup
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
module kwu_top #(
   parameter int SLOTS = kwu_pkg::KWU_SLOTS,
   parameter int IMPL  = kwu_pkg::KWU_PINS_IMP
) (
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Key pins and pad control
   input  wire logic [SLOTS-1:0] key_input_pin,
   output logic      [SLOTS-1:0] pin_pull_down,
   // System side
   input  wire logic             debug_halt,
   output logic                  cpu_irq_req,
   output logic                  wakeup_req,
   output logic                  event_irq
);
   import kwu_pkg::*;

   // Configuration state
   logic [SLOTS-1:0] pin_sense_enable;
   logic [SLOTS-1:0] pin_polarity_select;
   logic             level_sense_mode;
   logic             irq_request_enable;
   logic             detect_flag;

   // Power and event state
   logic [1:0]       pwr_mode_reg;
   logic             deep_prev_reg;
   logic [1:0]       ev_status_reg;
   logic [1:0]       ev_mask_reg;

   // Pins and detection results
   logic [SLOTS-1:0] pin_sync;
   logic [SLOTS-1:0] live_enable;
   logic             edge_seen;
   logic             any_asserted;

   // Bus strobes
   logic             wr_acc;
   logic             rd_acc;
   logic             ack_wr;
   logic             wr_ctrl;
   logic             wr_pinen;
   logic             wr_pol;
   logic             wr_pwr;
   logic             wr_irqst;
   logic             wr_irqmsk;
   logic [31:0]      rd_word;

   // Derived controls
   logic             deep_stop;
   logic             deep_exit;
   logic             set_flag;
   logic             wake_next;
   logic [1:0]       ev_set;

   // Address compare helper
   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a[11:2] == ofs[11:2]);
   endfunction

   // APB access strobes; zero wait states
   assign wr_acc    = psel & penable & pwrite;
   assign rd_acc    = psel & ~penable & ~pwrite;
   assign ack_wr    = wr_ctrl & pwdata[KWU_ACK_BIT];

   // Per-register write strobes, access phase only
   assign wr_ctrl   = wr_acc & hit(paddr, KWU_CTRL_OFS);
   assign wr_pinen  = wr_acc & hit(paddr, KWU_PINEN_OFS);
   assign wr_pol    = wr_acc & hit(paddr, KWU_POL_OFS);
   assign wr_pwr    = wr_acc & hit(paddr, KWU_PWR_OFS);
   assign wr_irqst  = wr_acc & hit(paddr, KWU_IRQST_OFS);
   assign wr_irqmsk = wr_acc & hit(paddr, KWU_IRQMSK_OFS);

   assign deep_stop   = (pwr_mode_reg == KWU_PWR_DEEP);
   assign deep_exit   = deep_prev_reg & ~deep_stop;
   assign live_enable = pin_sense_enable & {SLOTS{~deep_stop}};

   // Pin synchroniser
   kwu_sync #(.WIDTH(SLOTS)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (key_input_pin),
      .sync_out (pin_sync)
   );

   // Detection core; enables masked off in deep stop
   // seven live slots
   kwu_detect #(.SLOTS(SLOTS), .IMPL(IMPL)) u_det (
      .pclk                (pclk),
      .presetn             (presetn),
      .pin_level           (pin_sync),
      .pin_sense_enable    (live_enable),
      .pin_polarity_select (pin_polarity_select),
      .edge_seen           (edge_seen),
      .any_asserted        (any_asserted)
   );

   assign set_flag = edge_seen | (level_sense_mode & any_asserted);

   // Power mode register; a wakeup returns it to run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_mode_reg <= KWU_PWR_RUN;
      end else if (wr_pwr) begin
         pwr_mode_reg <= pwdata[1:0];
      end else if (wakeup_req) begin
         pwr_mode_reg <= KWU_PWR_RUN;  // Wake returns to run
      end
   end

   // Deep-stop history for exit detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deep_prev_reg <= 1'b0;
      end else begin
         deep_prev_reg <= deep_stop;
      end
   end

   // Pin sense enables
   // reset state after deep stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sense_enable <= KWU_PINEN_RST;
      end else if (deep_exit) begin
         pin_sense_enable <= KWU_PINEN_RST;
      end else if (wr_pinen) begin
         pin_sense_enable <= pwdata[SLOTS-1:0];
      end
   end

   // Polarity selects
   // polarity per slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_polarity_select <= KWU_POL_RST;
      end else if (deep_exit) begin
         pin_polarity_select <= KWU_POL_RST;
      end else if (wr_pol) begin
         pin_polarity_select <= pwdata[SLOTS-1:0];
      end
   end

   // Edge or edge-plus-level mode
   // level mode select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_sense_mode <= KWU_MODE_RST;
      end else if (deep_exit) begin
         level_sense_mode <= KWU_MODE_RST;
      end else if (wr_ctrl) begin
         level_sense_mode <= pwdata[KWU_MODE_BIT];
      end
   end

   // Irq request enable
   // reset after deep stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_request_enable <= KWU_IRQEN_RST;
      end else if (deep_exit) begin
         irq_request_enable <= KWU_IRQEN_RST;
      end else if (wr_ctrl) begin
         irq_request_enable <= pwdata[KWU_IRQEN_BIT];
      end
   end

   // Detect flag: set wins over acknowledge
   // set and acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         detect_flag <= KWU_FLAG_RST;
      end else if (deep_exit) begin
         detect_flag <= KWU_FLAG_RST;
      end else if (set_flag) begin
         detect_flag <= 1'b1;
      end else if (ack_wr) begin
         detect_flag <= 1'b0;
      end
   end

   assign wake_next = detect_flag & irq_request_enable &
                      ((pwr_mode_reg == KWU_PWR_WAIT) | (pwr_mode_reg == KWU_PWR_LIGHT));

   // Interrupt request toward the cpu
   // flag gated by enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_irq_req <= 1'b0;
      end else begin
         cpu_irq_req <= detect_flag & irq_request_enable & ~deep_exit;
      end
   end

   // One-cycle wakeup pulse
   // pulse per wake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wakeup_req <= 1'b0;
      end else begin
         wakeup_req <= wake_next & ~wakeup_req;
      end
   end

   // Pad pull direction
   // polarity selects pull-down
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_pull_down <= '0;
      end else begin
         pin_pull_down <= pin_polarity_select;
      end
   end

   // Sticky event status, write one to clear, set wins
   // new flag event
   assign ev_set = {wakeup_req, set_flag & ~detect_flag & ~deep_exit};

   // Event status register
   // cleared on deep-stop exit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_status_reg <= KWU_EV_RST;
      end else if (deep_exit) begin
         ev_status_reg <= KWU_EV_RST;
      end else if (wr_irqst) begin
         ev_status_reg <= (ev_status_reg & ~pwdata[1:0]) | ev_set;
      end else begin
         ev_status_reg <= ev_status_reg | ev_set;
      end
   end

   // Event mask register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_mask_reg <= KWU_EV_RST;
      end else if (deep_exit) begin
         ev_mask_reg <= KWU_EV_RST;
      end else if (wr_irqmsk) begin
         ev_mask_reg <= pwdata[1:0];
      end
   end

   // Level interrupt from unmasked status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_irq <= 1'b0;
      end else begin
         event_irq <= |(ev_status_reg & ev_mask_reg);
      end
   end

   // Read word selected by the address
   always_comb begin
      rd_word = '0;
      if (hit(paddr, KWU_CTRL_OFS)) begin
         rd_word[KWU_FLAG_BIT]  = detect_flag;
         rd_word[KWU_IRQEN_BIT] = irq_request_enable;
         rd_word[KWU_MODE_BIT]  = level_sense_mode;
      end else if (hit(paddr, KWU_PINEN_OFS)) begin
         rd_word[SLOTS-1:0] = pin_sense_enable;
      end else if (hit(paddr, KWU_POL_OFS)) begin
         rd_word[SLOTS-1:0] = pin_polarity_select;
      end else if (hit(paddr, KWU_PWR_OFS)) begin
         rd_word[1:0] = pwr_mode_reg;
      end else if (hit(paddr, KWU_IRQST_OFS)) begin
         rd_word[1:0] = ev_status_reg;
      end else if (hit(paddr, KWU_IRQMSK_OFS)) begin
         rd_word[1:0] = ev_mask_reg;
      end else if (hit(paddr, KWU_PINST_OFS)) begin
         rd_word[SLOTS-1:0] = pin_sync;
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (rd_acc) begin
         prdata <= rd_word;
      end
   end

   // Ready for every access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & ~penable;
      end
   end

   // Error for unmapped addresses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel & ~penable & (paddr > KWU_PINST_OFS);
      end
   end

endmodule

// ### design/kwu_pkg.sv
// Package with register map, field positions and reset values of the key wakeup block
package kwu_pkg;

   // Register byte offsets on the APB
   localparam logic [11:0] KWU_CTRL_OFS    = 12'h000;  // Status and control
   localparam logic [11:0] KWU_PINEN_OFS   = 12'h004;  // Pin sense enables
   localparam logic [11:0] KWU_POL_OFS     = 12'h008;  // Polarity selects
   localparam logic [11:0] KWU_PWR_OFS     = 12'h00C;  // Power mode control
   localparam logic [11:0] KWU_IRQST_OFS   = 12'h010;  // Sticky event status
   localparam logic [11:0] KWU_IRQMSK_OFS  = 12'h014;  // Event mask
   localparam logic [11:0] KWU_PINST_OFS   = 12'h018;  // Synchronised pin levels

   // Control register fields
   localparam int KWU_MODE_BIT  = 0;   // Level sense mode
   localparam int KWU_IRQEN_BIT = 1;   // Irq request enable
   localparam int KWU_ACK_BIT   = 2;   // Flag acknowledge, reads zero
   localparam int KWU_FLAG_BIT  = 3;   // Detect flag, read only

   // Power mode field (two bits)
   localparam logic [1:0] KWU_PWR_RUN   = 2'h0;
   localparam logic [1:0] KWU_PWR_WAIT  = 2'h1;
   localparam logic [1:0] KWU_PWR_LIGHT = 2'h2;
   localparam logic [1:0] KWU_PWR_DEEP  = 2'h3;

   // Event status bits
   localparam int KWU_EV_DETECT = 0;   // Detect flag was set
   localparam int KWU_EV_WAKE   = 1;   // Wakeup was issued

   // Reset values
   localparam logic [7:0] KWU_PINEN_RST  = 8'h00;
   localparam logic [7:0] KWU_POL_RST    = 8'h00;
   localparam logic [1:0] KWU_EV_RST     = 2'h0;
   localparam logic       KWU_MODE_RST   = 1'h0;
   localparam logic       KWU_IRQEN_RST  = 1'h0;
   localparam logic       KWU_FLAG_RST   = 1'h0;

   // Geometry
   localparam int KWU_SLOTS    = 8;    // Slots in the architecture
   localparam int KWU_PINS_IMP = 7;    // Implemented pins

endpackage

// ### design/kwu_sync.sv
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module kwu_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;

   // First stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// ### design/kwu_detect.sv
// Per-slot polarity, enable, edge and level detection
`timescale 1ns/1ps
module kwu_detect #(
   parameter int SLOTS = 8,
   parameter int IMPL  = 7
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Synchronised pins and configuration
   input  wire logic [SLOTS-1:0] pin_level,
   input  wire logic [SLOTS-1:0] pin_sense_enable,
   input  wire logic [SLOTS-1:0] pin_polarity_select,
   // Results
   output logic                  edge_seen,
   output logic                  any_asserted
);

   logic [SLOTS-1:0] asserted;
   logic [SLOTS-1:0] prev_reg;
   logic             armed_reg;

   // Asserted level per slot; unimplemented slots forced off
   // per-pin enable gating
   genvar g;
   generate
      for (g = 0; g < SLOTS; g++) begin : g_slot
         if (g < IMPL) begin : g_imp
            assign asserted[g] = pin_sense_enable[g] &
                                 ~(pin_level[g] ^ pin_polarity_select[g]);
         end else begin : g_dead
            assign asserted[g] = 1'b0;
         end
      end
   endgenerate

   assign any_asserted = |asserted;

   // Previous asserted state per slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= asserted;
      end
   end

   // Rearm once all enabled inputs are deasserted
   // rearm after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_reg <= 1'b0;
      end else if (!any_asserted) begin
         armed_reg <= 1'b1;
      end else if (edge_seen) begin
         armed_reg <= 1'b0;
      end
   end

   assign edge_seen = armed_reg & |(asserted & ~prev_reg);

endmodule

// ### tb/kwu_keys.sv
// Model of the switches on the key pins
`timescale 1ns/1ps
module kwu_keys #(
   parameter int SLOTS = 8
) (
   // Wanted switch levels
   input  wire logic [SLOTS-1:0] want,
   // Pins
   output logic      [SLOTS-1:0] key_input_pin
);
   // Pins follow the wanted levels off the clock edge
   // levels held many cycles
   assign #13 key_input_pin = want;
endmodule

// ### tb/kwu_top_properties.sv
// Checker of bus answers, pad pulls and wakeup pulses
`timescale 1ns/1ps
module kwu_props
   import kwu_pkg::*;
#(
   parameter int SLOTS = 8
) (
   // Clock and reset
   input wire logic             pclk,
   input wire logic             presetn,
   // Bus and outputs
   input wire logic             psel,
   input wire logic             penable,
   input wire logic             pwrite,
   input wire logic [11:0]      paddr,
   input wire logic [31:0]      pwdata,
   input wire logic [31:0]      prdata,
   input wire logic             pready,
   input wire logic             pslverr,
   input wire logic [SLOTS-1:0] pin_pull_down,
   input wire logic             wakeup_req
);
   logic [1:0] mode_reg;
   logic       acc;
   assign acc = psel && penable && pready;
   // Mirror of the power mode set by software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= KWU_PWR_RUN;
      end else if (acc && pwrite && paddr == KWU_PWR_OFS) begin
         mode_reg <= pwdata[1:0];
      end else if (wakeup_req) begin
         mode_reg <= KWU_PWR_RUN;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_unmapped: assert property (psel && !penable && paddr > KWU_PINST_OFS |=> pslverr)
      else $error("no error on unmapped address");
   a_err_mapped: assert property (psel && !penable && paddr <= KWU_PINST_OFS |=> !pslverr)
      else $error("error on mapped address");
   a_pull_follows_pol: assert property (
      acc && pwrite && paddr == KWU_POL_OFS |-> ##2 pin_pull_down == $past(pwdata[SLOTS-1:0], 2))
      else $error("pad pull differs from polarity");
   a_ack_reads_zero: assert property (
      acc && !pwrite && paddr == KWU_CTRL_OFS |-> !prdata[KWU_ACK_BIT] && prdata[31:4] == 28'h0)
      else $error("acknowledge or unused bits read one");
   a_wake_single: assert property (wakeup_req |=> !wakeup_req)
      else $error("wakeup longer than one cycle");
   a_deep_no_wake: assert property (
      $past(mode_reg) == KWU_PWR_DEEP && mode_reg == KWU_PWR_DEEP |-> !wakeup_req)
      else $error("wakeup in deep stop");
endmodule
bind kwu_top kwu_props #(.SLOTS(SLOTS)) kwu_props_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_pull_down(pin_pull_down),
   .wakeup_req(wakeup_req));

// ### tb/tb_kwu_top.sv
// Self-checking bench of the key wakeup block
`timescale 1ns/1ps
module tb_kwu_top;
   import kwu_pkg::*;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} kwu_note_t;
   logic        pclk, presetn, psel, penable, pwrite, debug_halt, pready, pslverr;
   logic        cpu_irq_req, wakeup_req, event_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [7:0]  want, keys, pull;
   int          n_fail, checks_done, wake_cnt, seed;
   kwu_note_t   notes[$];
   kwu_note_t   note;
   kwu_top #(.SLOTS(8), .IMPL(7)) kwu_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .key_input_pin(keys), .pin_pull_down(pull),
      .debug_halt(debug_halt), .cpu_irq_req(cpu_irq_req), .wakeup_req(wakeup_req),
      .event_irq(event_irq));
   kwu_keys #(.SLOTS(8)) kwu_keys_i (.want(want), .key_input_pin(keys));
   // Bus clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk("pready", 1, 32'(pready));
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
      notes.push_back('{d, m, a > KWU_PINST_OFS});
      apb(1'b0, a, 32'h0);
   endtask
   task press(input logic [7:0] v);
      want <= v;
      repeat (8) @(posedge pclk);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Read results compared against the oldest note
   always @(posedge pclk) begin
      if (wakeup_req === 1'b1) wake_cnt++;
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         note = notes.pop_front();
         chk("prdata", note.d, prdata & note.m);
         chk("pslverr", 32'(note.e), 32'(pslverr));
      end
   end
   // Watchdog
   initial begin
      #200000;
      n_fail++;
      summarize;
   end
   // Main sequence
   initial begin
      seed = 32'h9B92AB46;
      {n_fail, checks_done, wake_cnt} = '0;
      {presetn, psel, penable, pwrite, debug_halt} = '0;
      paddr = 12'h000;
      pwdata = 32'h0;
      want = 8'hFF;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(KWU_PINEN_OFS, 32'h0, '1);
      rd(KWU_CTRL_OFS, 32'h0, '1);
      r = $random(seed);
      wr(KWU_POL_OFS, r);
      rd(KWU_POL_OFS, {24'h0, r[7:0]}, '1);
      chk("pin_pull_down", {24'h0, r[7:0]}, {24'h0, pull});
      wr(KWU_POL_OFS, 32'h0);
      wr(KWU_PINEN_OFS, 32'h7F);
      wr(KWU_CTRL_OFS, 32'h6);
      press(8'hFE);
      rd(KWU_CTRL_OFS, 32'hA, '1);
      chk("cpu_irq_req", 1, 32'(cpu_irq_req));
      wr(KWU_CTRL_OFS, 32'h6);
      rd(KWU_CTRL_OFS, 32'h2, '1);
      press(8'hF6);
      rd(KWU_CTRL_OFS, 32'h2, '1);
      press(8'hFF);
      press(8'hBF);
      rd(KWU_CTRL_OFS, 32'hA, '1);
      press(8'hFF);
      wr(KWU_CTRL_OFS, 32'h6);
      wr(KWU_PINEN_OFS, 32'hFF);
      press(8'h7F);
      rd(KWU_CTRL_OFS, 32'h2, '1);
      press(8'hFF);
      wr(KWU_CTRL_OFS, 32'h3);
      press(8'hFD);
      wr(KWU_CTRL_OFS, 32'h7);
      rd(KWU_CTRL_OFS, 32'hB, '1);
      press(8'hFF);
      wr(KWU_CTRL_OFS, 32'h7);
      rd(KWU_CTRL_OFS, 32'h3, '1);
      rd(KWU_IRQST_OFS, 32'h1, '1);
      wr(KWU_IRQMSK_OFS, 32'h1);
      repeat (2) @(posedge pclk);
      chk("event_irq", 1, 32'(event_irq));
      wr(KWU_IRQST_OFS, 32'h3);
      repeat (2) @(posedge pclk);
      chk("event_irq", 0, 32'(event_irq));
      wr(KWU_CTRL_OFS, 32'h6);
      debug_halt <= 1'b1;
      for (int i = 1; i < 3; i++) begin
         wr(KWU_PWR_OFS, 32'(i));
         press(8'hFE);
         chk("wakeup count", 32'(i), 32'(wake_cnt));
         rd(KWU_PWR_OFS, 32'h0, '1);
         rd(KWU_CTRL_OFS, 32'hA, '1);
         press(8'hFF);
         wr(KWU_CTRL_OFS, 32'h6);
      end
      rd(KWU_IRQST_OFS, 32'h2, 32'h2);
      wr(KWU_PWR_OFS, 32'(KWU_PWR_DEEP));
      press(8'hFE);
      rd(KWU_CTRL_OFS, 32'h0, 32'h8);
      wr(KWU_PWR_OFS, 32'(KWU_PWR_RUN));
      rd(KWU_PINEN_OFS, 32'h0, '1);
      rd(KWU_CTRL_OFS, 32'h0, '1);
      rd(KWU_IRQST_OFS, 32'h0, '1);
      rd(KWU_IRQMSK_OFS, 32'h0, '1);
      press(8'hFF);
      wr(12'h01C, $random(seed));
      rd(12'h01C, 32'h0, '1);
      rd(12'hFFC, 32'h0, '1);
      summarize;
   end
endmodule
